// ---- hdl/sequencer_regs.vh ----
// Register map, field positions, reset values and timing for the sequencer
`ifndef SEQUENCER_REGS_VH
`define SEQUENCER_REGS_VH

// ****************************************************************
// Register bus
// ****************************************************************
`define ADDR_W          6
`define DATA_W          32
`define RDATA_PAD       24'h00_0000

// Register indices; byte address is four times the index
`define IDX_TIMER       6'h01
`define IDX_STATUS      6'h03
`define IDX_PORT_DATA   6'h06
`define IDX_PWRCTL      6'h08
`define IDX_WAKE_EN     6'h09
`define IDX_PULLDOWN    6'h0B
`define IDX_OPENDRAIN   6'h0C
`define IDX_PULLHIGH    6'h0D
`define IDX_IRQ_EN      6'h0E
`define IDX_IRQ_FLAG    6'h0F
`define IDX_PIN_DIR     6'h16

// ****************************************************************
// Field positions
// ****************************************************************
`define STAT_TIMEOUT    4
`define STAT_POWERDOWN  3
`define PWRCTL_WDOG_EN  7
`define PWRCTL_EXT_SEL  6
`define IRQ_GLOBAL      7
`define IRQ_EXT         2
`define IRQ_PINCHG      1
`define IRQ_TIMER       0

// ****************************************************************
// Reset values and masks
// ****************************************************************
`define BYTE_ONES       8'hFF
`define BYTE_ZERO       8'h00
`define STATUS_POR      8'h18
`define PWRCTL_RST      8'hA0
`define PWRCTL_MASK     8'hF0
`define IRQ_EN_MASK     8'h87
`define IRQ_FLAG_MASK   8'h07
`define TIMER_WRAP      8'hFF
`define IRQ_VECTOR      12'h008

// ****************************************************************
// Timing
// ****************************************************************
`define DELAY_DEF       19'h5_7E40
`define DELAY_W         19
`define OSC_EDGES       8'h80

`endif

// ---- hdl/settle_timer.v ----
// Power-up delay timer followed by the oscillator settle counter
`timescale 1ns/1ps
`include "sequencer_regs.vh"

module settle_timer #(
  parameter [`DELAY_W-1:0] DELAY_CYCLES = `DELAY_DEF
) (
  input  wire clk_i,
  input  wire rstn_i,
  input  wire ce_i,
  input  wire clear_i,
  input  wire osc_input_pin_i,
  input  wire osc_amp_ok_i,
  output wire done_o
);

  localparam [`DELAY_W-1:0] DELAY_LAST = DELAY_CYCLES - 1'b1;

  reg [`DELAY_W-1:0] delay_cnt_r;
  reg [7:0]          osc_cnt_r;
  reg                osc_prev_r;

  wire delay_done = (delay_cnt_r == DELAY_LAST);
  wire osc_done   = (osc_cnt_r == `OSC_EDGES);
  // Edges only count once the input swing crosses the thresholds
  wire osc_edge   = osc_input_pin_i & ~osc_prev_r & osc_amp_ok_i;

  // ****************************************************************
  // Counters
  // ****************************************************************
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      delay_cnt_r <= {`DELAY_W{1'b0}};
      osc_cnt_r   <= `BYTE_ZERO;
      osc_prev_r  <= 1'b0;
    end else if (ce_i) begin
      osc_prev_r <= osc_input_pin_i;
      if (clear_i) begin
        delay_cnt_r <= {`DELAY_W{1'b0}};
        osc_cnt_r   <= `BYTE_ZERO;
      end else if (!delay_done) begin
        delay_cnt_r <= delay_cnt_r + 1'b1;
      end else if (!osc_done && osc_edge) begin
        osc_cnt_r <= osc_cnt_r + 1'b1;
      end
    end
  end

  assign done_o = delay_done & osc_done;

endmodule // settle_timer

// ---- hdl/reset_sleep_wake_sequencer.v ----
// Reset, sleep and wake-up sequencing with its register slave
`timescale 1ns/1ps
`include "sequencer_regs.vh"

// Summary of operation
// - Timer wrap from FFh to 00h sets the timer flag; enable masks it.
// - Enabled change on any watched port pin sets the pin-change flag.
// - Pin ignored when wake bit is 0, pin is output, or bit 0 is external.
// - External or pin-change source wakes sleep if enabled, regardless of global.
// - After wake resume next instruction; with global enable, vector to 008h.
// - Sleep clears power-down, sets timeout, clears watchdog, stops oscillator.
// - Pins keep their level and direction throughout sleep.
// - Reset pin or watchdog during sleep gives a full reset, not resume.
// - Wake-up waits the 18ms delay plus 128 oscillator cycles.
// - Reset comes from power-on, brown-out, reset pin or watchdog timeout.
// - Low supply detection holds reset for as long as it lasts.
// - After any reset an 18ms delay timer runs while reset is held.
// - Then 128 oscillator edges are counted once amplitude is adequate.
// - Reset event sets latch and clears timers; release after both finish.
// - Timeout and power-down flags follow the cause of each reset.
// - Power-down set at power-up, cleared by sleep; watchdog clears timeout.
// - Every reset loads direction, pull, open-drain, wake and irq defaults.
// - Timer count and undefined state survive any reset except power-on.
// - Non pin-change flags set regardless of mask; reads return flag AND enable.
// - Taken interrupt clears global enable and fetches from 008h.
// - External input select on bit 0 disables its change and wake function.
module reset_sleep_wake_sequencer #(
  parameter [`DELAY_W-1:0] DELAY_CYCLES = `DELAY_DEF,
  parameter [`DELAY_W-1:0] WDOG_CYCLES  = `DELAY_DEF
) (
  input  wire               clk_i,
  input  wire               rstn_i,
  input  wire               ce_i,
  input  wire [`ADDR_W-1:0] avs_address_i,
  input  wire               avs_read_i,
  input  wire               avs_write_i,
  input  wire [`DATA_W-1:0] avs_writedata_i,
  output wire [`DATA_W-1:0] avs_readdata_o,
  output wire               avs_waitrequest_o,
  input  wire               brownout_i,
  input  wire               external_reset_pin_n_i,
  input  wire               osc_input_pin_i,
  input  wire               osc_amp_ok_i,
  input  wire               instr_phase_i,
  input  wire               sleep_instr_i,
  input  wire               watchdog_clear_i,
  input  wire               timer_tick_i,
  input  wire [7:0]         second_port_pins_i,
  output wire [7:0]         second_port_out_o,
  output wire [7:0]         second_port_oe_o,
  output wire [7:0]         pull_high_ctl_o,
  output wire [7:0]         pull_down_ctl_o,
  output wire               core_reset_o,
  output wire               sleeping_o,
  output wire               osc_enable_o,
  output wire               resume_o,
  output wire               irq_vector_o
);

  // ****************************************************************
  // States and constants
  // ****************************************************************
  localparam [2:0] ST_HOLD   = 3'h0;
  localparam [2:0] ST_SETTLE = 3'h1;
  localparam [2:0] ST_RUN    = 3'h2;
  localparam [2:0] ST_SLEEP  = 3'h3;
  localparam [2:0] ST_WAKE   = 3'h4;

  localparam [`DELAY_W-1:0] WDOG_LAST = WDOG_CYCLES - 1'b1;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg  [2:0]          state_r;
  reg  [2:0]          state_nxt;
  reg                 ack_r;
  reg  [7:0]          readdata_r;
  reg  [7:0]          rd_mux;
  reg  [`DELAY_W-1:0] watchdog_cnt_r;
  reg  [7:0]          timer_count_r;
  reg  [7:0]          status_r;
  reg  [7:0]          pwrctl_r;
  reg  [7:0]          pin_wake_enable_reg_r;
  reg  [7:0]          pulldown_r;
  reg  [7:0]          opendrain_r;
  reg  [7:0]          pullhigh_r;
  reg  [7:0]          pin_dir_r;
  reg  [7:0]          port_data_r;
  reg  [7:0]          change_ref_r;
  reg  [7:0]          irq_enable_reg_r;
  reg  [7:0]          irq_flag_reg_r;
  reg  [7:0]          pin_out_r;
  reg  [7:0]          pin_oe_r;
  reg                 pin0_prev_r;
  reg                 resume_r;
  reg                 vector_r;
  wire [7:0]          watched;
  wire [7:0]          changed;
  wire                settle_done;

  // ****************************************************************
  // Bus slave: one wait state, then the access is taken
  // ****************************************************************
  wire       bus_req  = avs_read_i | avs_write_i;
  wire       wr_take  = avs_write_i & ack_r;
  wire       rd_take  = avs_read_i & ack_r;
  wire [7:0] wdata    = avs_writedata_i[7:0];
  wire       wr_timer = wr_take & (avs_address_i == `IDX_TIMER);
  wire       wr_stat  = wr_take & (avs_address_i == `IDX_STATUS);
  wire       wr_port  = wr_take & (avs_address_i == `IDX_PORT_DATA);
  wire       wr_pwr   = wr_take & (avs_address_i == `IDX_PWRCTL);
  wire       wr_wake  = wr_take & (avs_address_i == `IDX_WAKE_EN);
  wire       wr_pdn   = wr_take & (avs_address_i == `IDX_PULLDOWN);
  wire       wr_od    = wr_take & (avs_address_i == `IDX_OPENDRAIN);
  wire       wr_phi   = wr_take & (avs_address_i == `IDX_PULLHIGH);
  wire       wr_ien   = wr_take & (avs_address_i == `IDX_IRQ_EN);
  wire       wr_flag  = wr_take & (avs_address_i == `IDX_IRQ_FLAG);
  wire       wr_dir   = wr_take & (avs_address_i == `IDX_PIN_DIR);
  wire       port_hit = (wr_take | rd_take) &
                        (avs_address_i == `IDX_PORT_DATA);

  // A frozen clock enable keeps the master waiting
  assign avs_waitrequest_o = bus_req & ~(ack_r & ce_i);
  assign avs_readdata_o    = {`RDATA_PAD, readdata_r};

  always @* begin
    case (avs_address_i)
      `IDX_TIMER:     rd_mux = timer_count_r;
      `IDX_STATUS:    rd_mux = status_r;
      `IDX_PORT_DATA: rd_mux = second_port_pins_i;
      `IDX_PWRCTL:    rd_mux = pwrctl_r;
      `IDX_WAKE_EN:   rd_mux = pin_wake_enable_reg_r;
      `IDX_PULLDOWN:  rd_mux = pulldown_r;
      `IDX_OPENDRAIN: rd_mux = opendrain_r;
      `IDX_PULLHIGH:  rd_mux = pullhigh_r;
      `IDX_IRQ_EN:    rd_mux = irq_enable_reg_r;
      `IDX_IRQ_FLAG:  rd_mux = irq_flag_reg_r & irq_enable_reg_r;
      `IDX_PIN_DIR:   rd_mux = pin_dir_r;
      default:        rd_mux = `BYTE_ZERO;
    endcase
  end

  // ****************************************************************
  // Event decode
  // ****************************************************************
  wire running  = (state_r == ST_RUN);
  wire asleep   = (state_r == ST_SLEEP) | (state_r == ST_WAKE);
  wire wdog_on  = pwrctl_r[`PWRCTL_WDOG_EN] & (running | asleep);
  wire wdog_to  = wdog_on & (watchdog_cnt_r == WDOG_LAST);
  // Brown-out is a level, so reset is held as long as supply is low
  wire rst_src  = brownout_i | ~external_reset_pin_n_i | wdog_to;
  wire rst_entry = rst_src & (state_r != ST_HOLD);
  wire reg_reset = rst_src | (state_r == ST_HOLD);
  wire ext_sel  = pwrctl_r[`PWRCTL_EXT_SEL];
  wire sleep_go = running & sleep_instr_i & ~rst_src;

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_watch
      assign watched[i] = pin_wake_enable_reg_r[i] & pin_dir_r[i] &
                          ~((i == 0) & ext_sel);
      assign changed[i] = watched[i] &
                          (second_port_pins_i[i] ^ change_ref_r[i]);
    end
  endgenerate

  wire pinchg_set = (|changed) & irq_enable_reg_r[`IRQ_PINCHG];
  wire ext_set    = ext_sel & second_port_pins_i[0] & ~pin0_prev_r;
  wire timer_set  = running & timer_tick_i &
                    (timer_count_r == `TIMER_WRAP);
  wire [2:0] flag_set = {ext_set, pinchg_set, timer_set};
  wire [2:0] armed    = irq_flag_reg_r[2:0] & irq_enable_reg_r[2:0];
  wire global_en      = irq_enable_reg_r[`IRQ_GLOBAL];
  // Only the external and pin-change sources can wake the part
  wire wake_req  = armed[`IRQ_EXT] | armed[`IRQ_PINCHG];
  wire take_irq  = running & global_en & (|armed) & ~rst_src;
  wire release_ok = settle_done & instr_phase_i;
  wire wake_done = (state_r == ST_WAKE) & release_ok & ~rst_src;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_HOLD:   if (!rst_src) state_nxt = ST_SETTLE;
      ST_SETTLE: if (release_ok) state_nxt = ST_RUN;
      ST_RUN:    if (sleep_instr_i) state_nxt = ST_SLEEP;
      ST_SLEEP:  if (wake_req) state_nxt = ST_WAKE;
      ST_WAKE:   if (release_ok) state_nxt = ST_RUN;
      default:   state_nxt = ST_HOLD;
    endcase
    // Any reset source, also from sleep, restarts the sequence
    if (rst_src) begin
      state_nxt = ST_HOLD;
    end
  end

  // Timers only count while the latch waits or the part wakes
  settle_timer #(
    .DELAY_CYCLES    (DELAY_CYCLES)
  ) u_settle (
    .clk_i           (clk_i),
    .rstn_i          (rstn_i),
    .ce_i            (ce_i),
    .clear_i         ((state_r != ST_SETTLE) & (state_r != ST_WAKE)),
    .osc_input_pin_i (osc_input_pin_i),
    .osc_amp_ok_i    (osc_amp_ok_i),
    .done_o          (settle_done)
  );

  always @(posedge clk_i) begin
    if (!rstn_i) begin
      state_r        <= ST_HOLD;
      ack_r          <= 1'b0;
      readdata_r     <= `BYTE_ZERO;
      watchdog_cnt_r <= {`DELAY_W{1'b0}};
      resume_r       <= 1'b0;
      vector_r       <= 1'b0;
      pin0_prev_r    <= 1'b0;
    end else if (ce_i) begin
      state_r     <= state_nxt;
      ack_r       <= bus_req & ~ack_r;
      pin0_prev_r <= second_port_pins_i[0];
      if (avs_read_i && !ack_r) begin
        readdata_r <= rd_mux;
      end
      // Watchdog keeps running through sleep, restarted on entry
      if (reg_reset || sleep_go || watchdog_clear_i || !wdog_on) begin
        watchdog_cnt_r <= {`DELAY_W{1'b0}};
      end else begin
        watchdog_cnt_r <= watchdog_cnt_r + 1'b1;
      end
      resume_r <= wake_done & ~global_en;
      vector_r <= take_irq | (wake_done & global_en);
    end
  end

  // ****************************************************************
  // Status flags
  // ****************************************************************
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      status_r <= `STATUS_POR;
    end else if (ce_i) begin
      if (wr_stat) begin
        status_r[7:5] <= wdata[7:5];
        status_r[2:0] <= wdata[2:0];
      end
      if (rst_entry) begin
        status_r[7:5] <= 3'h0;
        if (brownout_i) begin
          status_r[`STAT_TIMEOUT]   <= 1'b1;
          status_r[`STAT_POWERDOWN] <= 1'b1;
        end else if (wdog_to) begin
          status_r[`STAT_TIMEOUT]   <= 1'b0;
          status_r[`STAT_POWERDOWN] <= ~asleep;
        end else if (asleep) begin
          status_r[`STAT_TIMEOUT]   <= 1'b1;
          status_r[`STAT_POWERDOWN] <= 1'b0;
        end
      end else if (sleep_go) begin
        status_r[`STAT_TIMEOUT]   <= 1'b1;
        status_r[`STAT_POWERDOWN] <= 1'b0;
      end else if (running && watchdog_clear_i) begin
        status_r[`STAT_TIMEOUT]   <= 1'b1;
        status_r[`STAT_POWERDOWN] <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Configuration and interrupt registers
  // ****************************************************************
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      timer_count_r <= `BYTE_ZERO;
      port_data_r   <= `BYTE_ZERO;
      change_ref_r  <= `BYTE_ZERO;
    end else if (ce_i) begin
      // No reload on reset: contents survive all but power-on
      if (wr_timer) begin
        timer_count_r <= wdata;
      end else if (running && timer_tick_i) begin
        timer_count_r <= timer_count_r + 1'b1;
      end
      if (wr_port) begin
        port_data_r <= wdata;
      end
      // The reference is only refreshed by a port data access
      if (port_hit) begin
        change_ref_r <= second_port_pins_i;
      end
    end
  end

  always @(posedge clk_i) begin
    if (!rstn_i || (ce_i && reg_reset)) begin
      pwrctl_r              <= `PWRCTL_RST;
      pin_wake_enable_reg_r <= `BYTE_ZERO;
      pulldown_r            <= `BYTE_ONES;
      opendrain_r           <= `BYTE_ZERO;
      pullhigh_r            <= `BYTE_ONES;
      pin_dir_r             <= `BYTE_ONES;
      irq_enable_reg_r      <= `BYTE_ZERO;
      irq_flag_reg_r        <= `BYTE_ZERO;
    end else if (ce_i) begin
      if (wr_pwr) pwrctl_r <= wdata & `PWRCTL_MASK;
      if (wr_wake) pin_wake_enable_reg_r <= wdata;
      if (wr_pdn) pulldown_r <= wdata;
      if (wr_od) opendrain_r <= wdata;
      if (wr_phi) pullhigh_r <= wdata;
      if (wr_dir) pin_dir_r <= wdata;
      if (wr_ien) begin
        irq_enable_reg_r <= wdata & `IRQ_EN_MASK;
      end
      if (take_irq || wake_done) begin
        irq_enable_reg_r[`IRQ_GLOBAL] <= 1'b0;
      end
      // A flag event in the clearing cycle wins over the clear
      irq_flag_reg_r <= ((wr_flag ? wdata : irq_flag_reg_r) |
                         {5'h00, flag_set}) & `IRQ_FLAG_MASK;
    end
  end

  // ****************************************************************
  // Pin drive, frozen while asleep
  // ****************************************************************
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      pin_out_r <= `BYTE_ZERO;
      pin_oe_r  <= `BYTE_ZERO;
    end else if (ce_i && !asleep) begin
      pin_out_r <= port_data_r;
      pin_oe_r  <= ~pin_dir_r & ~(opendrain_r & port_data_r);
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign second_port_out_o = pin_out_r;
  assign second_port_oe_o  = pin_oe_r;
  assign pull_high_ctl_o   = pullhigh_r;
  assign pull_down_ctl_o   = pulldown_r;
  // Latch covers the hold, delay and settle phases
  assign core_reset_o      = (state_r == ST_HOLD) |
                             (state_r == ST_SETTLE);
  assign sleeping_o        = asleep;
  assign osc_enable_o      = (state_r != ST_SLEEP);
  assign resume_o          = resume_r;
  assign irq_vector_o      = vector_r;

endmodule // reset_sleep_wake_sequencer

// ---- dv/reset_sleep_wake_sequencer_asserts.sv ----
// Port checker for the reset, sleep and wake sequencer
`timescale 1ns/1ps
`include "sequencer_regs.vh"

module seq_checker #(
  parameter [`DELAY_W-1:0] DELAY_CYCLES = 19'h0_0014
) (
  input wire       clk_i,
  input wire       rstn_i,
  input wire       ce_i,
  input wire       avs_read_i,
  input wire       avs_write_i,
  input wire       avs_waitrequest_o,
  input wire       brownout_i,
  input wire       external_reset_pin_n_i,
  input wire       instr_phase_i,
  input wire       sleep_instr_i,
  input wire [7:0] second_port_out_o,
  input wire [7:0] second_port_oe_o,
  input wire       core_reset_o,
  input wire       sleeping_o,
  input wire       osc_enable_o,
  input wire       resume_o,
  input wire       irq_vector_o
);
  // ******************************
  // Helper logic and properties
  // ******************************
  // Saturates so a stuck reset cannot wrap and look short
  reg [19:0] held_r;
  always @(posedge clk_i) begin
    if (!rstn_i || !core_reset_o) held_r <= 20'h0_0000;
    else if (held_r != 20'hF_FFFF) held_r <= held_r + 20'h0_0001;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_run_sleep;
    sleep_instr_i && !core_reset_o && !sleeping_o && !brownout_i &&
      external_reset_pin_n_i;
  endsequence
  sequence s_asleep;
    sleeping_o && !osc_enable_o;
  endsequence
  property p_sleep_entry;
    s_run_sleep |=> s_asleep;
  endproperty
  property p_osc_off;
    !osc_enable_o |-> sleeping_o && !core_reset_o;
  endproperty
  property p_freeze;
    sleeping_o && $past(sleeping_o) |->
      $stable(second_port_out_o) && $stable(second_port_oe_o);
  endproperty
  property p_resume;
    resume_o |-> !sleeping_o && !core_reset_o ##1 !resume_o;
  endproperty
  property p_vector;
    irq_vector_o |=> !irq_vector_o && !core_reset_o;
  endproperty
  property p_brown;
    brownout_i |=> core_reset_o;
  endproperty
  property p_pin;
    !external_reset_pin_n_i |=> core_reset_o && !sleeping_o;
  endproperty
  property p_release;
    $fell(core_reset_o) |-> $past(instr_phase_i);
  endproperty
  property p_hold;
    $fell(core_reset_o) |-> held_r >= DELAY_CYCLES + 20'h0_0080;
  endproperty
  property p_wait;
    (avs_read_i || avs_write_i) && ce_i |-> ##[0:1] !avs_waitrequest_o;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep not entered");
  a_osc_off: assert property (p_osc_off)
    else $error("oscillator off outside sleep");
  a_freeze: assert property (p_freeze)
    else $error("pins moved during sleep");
  a_resume: assert property (p_resume)
    else $error("bad resume pulse");
  a_vector: assert property (p_vector)
    else $error("bad vector pulse");
  a_brown: assert property (p_brown)
    else $error("low supply did not hold reset");
  a_pin: assert property (p_pin)
    else $error("reset pin ignored");
  a_release: assert property (p_release)
    else $error("release off the instruction boundary");
  a_hold: assert property (p_hold)
    else $error("reset released too early");
  a_wait: assert property (p_wait)
    else $error("bus access not answered");
endmodule // seq_checker

bind reset_sleep_wake_sequencer seq_checker #(
  .DELAY_CYCLES(DELAY_CYCLES)) watch (
  .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .brownout_i(brownout_i), .external_reset_pin_n_i(external_reset_pin_n_i),
  .instr_phase_i(instr_phase_i), .sleep_instr_i(sleep_instr_i),
  .second_port_out_o(second_port_out_o),
  .second_port_oe_o(second_port_oe_o), .core_reset_o(core_reset_o),
  .sleeping_o(sleeping_o), .osc_enable_o(osc_enable_o),
  .resume_o(resume_o), .irq_vector_o(irq_vector_o));

// ---- dv/core_model.sv ----
// Processor core model issuing sleep and watchdog clear instructions
`timescale 1ns/1ps

module core_model (
  input  wire clk_i,
  output reg  instr_phase_o,
  output reg  sleep_instr_o,
  output reg  watchdog_clear_o
);
  // ******************************
  // Instruction boundary and issue
  // ******************************
  reg [1:0] ph_r;
  initial begin
    ph_r = 2'h0;
    instr_phase_o = 1'b0;
    sleep_instr_o = 1'b0;
    watchdog_clear_o = 1'b0;
  end
  // One boundary every four clocks, so release must wait for it
  always @(posedge clk_i) begin
    ph_r <= ph_r + 2'h1;
    instr_phase_o <= (ph_r == 2'h3);
  end
  task issue(input s);
    begin
      @(posedge clk_i);
      while (instr_phase_o !== 1'b1) @(posedge clk_i);
      sleep_instr_o <= s;
      watchdog_clear_o <= ~s;
      @(posedge clk_i);
      sleep_instr_o <= 1'b0;
      watchdog_clear_o <= 1'b0;
    end
  endtask
endmodule // core_model

// ---- dv/reset_sleep_wake_sequencer_bench.sv ----
// Self-checking bench for the reset, sleep and wake sequencer
`timescale 1ns/1ps
`include "sequencer_regs.vh"

module reset_sleep_wake_sequencer_bench;
  // ******************************
  // Stimulus, tasks and tests
  // ******************************
  localparam [`DELAY_W-1:0] DLY = 19'h0_0014;
  localparam [`DELAY_W-1:0] WDG = 19'h0_00C8;
  reg         clk_i, rstn_i, rd, wr, tick, brown, pin_n, osc, ce, amp;
  reg  [5:0]  adr;
  reg  [7:0]  pins;
  reg  [31:0] wdat, q;
  wire [31:0] rdat;
  wire [7:0]  pout, poe, phi, pdn;
  wire        wreq, crst, slp, osc_en, res, vec, phase, sli, wdc;
  integer     err_total, checked, cyc;
  reset_sleep_wake_sequencer #(.DELAY_CYCLES(DLY), .WDOG_CYCLES(WDG)) uut (
    .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .brownout_i(brown),
    .external_reset_pin_n_i(pin_n), .osc_input_pin_i(osc),
    .osc_amp_ok_i(amp), .instr_phase_i(phase), .sleep_instr_i(sli),
    .watchdog_clear_i(wdc), .timer_tick_i(tick),
    .second_port_pins_i(pins), .second_port_out_o(pout),
    .second_port_oe_o(poe), .pull_high_ctl_o(phi), .pull_down_ctl_o(pdn),
    .core_reset_o(crst), .sleeping_o(slp), .osc_enable_o(osc_en),
    .resume_o(res), .irq_vector_o(vec));
  core_model core (.clk_i(clk_i), .instr_phase_o(phase),
    .sleep_instr_o(sli), .watchdog_clear_o(wdc));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) osc <= ~osc;
  task test_done;
    begin
      if (err_total == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e);
    begin
      checked = checked + 1;
      if (s !== e) begin
        err_total = err_total + 1;
        $display("FAIL %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task bus(input w, input [5:0] a, input [7:0] d);
    begin
      adr <= a;
      wdat <= {24'h00_0000, d};
      rd <= ~w;
      wr <= w;
      @(posedge clk_i);
      while (wreq !== 1'b0) @(posedge clk_i);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task rchk(input [5:0] a, input [7:0] e);
    begin
      bus(1'b0, a, 8'h00);
      chk(q, {24'h00_0000, e});
    end
  endtask
  // Kinds: 0 release, 1 resume, 2 vector, 3 reset entry
  task wait_for(input integer k);
    begin
      cyc = 0;
      while (!(k == 0 ? crst === 1'b0 : k == 1 ? res === 1'b1 :
               k == 2 ? vec === 1'b1 : crst === 1'b1) && cyc < 3000) begin
        @(posedge clk_i);
        cyc = cyc + 1;
      end
      if (cyc >= 3000) chk(32'h0000_0000, 32'h0000_0001);
    end
  endtask
  task set_pins(input [7:0] v);
    begin
      pins <= v;
      repeat (4) @(posedge clk_i);
    end
  endtask
  task tick1;
    begin
      tick <= 1'b1;
      @(posedge clk_i);
      tick <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  // Brown-out or reset pin, held for c cycles
  task hit(input b, input integer c);
    begin
      if (b) brown <= 1'b1;
      else pin_n <= 1'b0;
      repeat (c) @(posedge clk_i);
      chk(crst, 1'b1);
      brown <= 1'b0;
      pin_n <= 1'b1;
      wait_for(0);
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total = err_total + 1;
    test_done;
  end
  initial begin
    rstn_i = 1'b0; rd = 1'b0; wr = 1'b0; tick = 1'b0; brown = 1'b0;
    pin_n = 1'b1; osc = 1'b0; adr = 6'h00; wdat = 32'h0000_0000;
    pins = 8'h00; q = 32'h0000_0000; err_total = 0; checked = 0;
    ce = 1'b1; amp = 1'b1;
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    wait_for(0);
    rchk(`IDX_PWRCTL, 8'hA0);
    bus(1'b1, `IDX_PWRCTL, 8'h20);
    rchk(`IDX_STATUS, 8'h18);
    rchk(`IDX_WAKE_EN, 8'h00);
    rchk(`IDX_PULLDOWN, 8'hFF);
    rchk(`IDX_OPENDRAIN, 8'h00);
    rchk(`IDX_PULLHIGH, 8'hFF);
    rchk(`IDX_IRQ_EN, 8'h00);
    rchk(`IDX_IRQ_FLAG, 8'h00);
    rchk(`IDX_PIN_DIR, 8'hFF);
    chk({phi, pdn, poe}, 24'hFF_FF00);
    bus(1'b1, 6'h3F, 8'h55);
    rchk(6'h3F, 8'h00);
    bus(1'b1, `IDX_TIMER, 8'hFE);
    ce <= 1'b0;
    tick1;
    ce <= 1'b1;
    tick1;
    rchk(`IDX_TIMER, 8'hFF);
    bus(1'b1, `IDX_IRQ_EN, 8'h01);
    rchk(`IDX_IRQ_FLAG, 8'h00);
    bus(1'b1, `IDX_IRQ_EN, 8'h00);
    tick1;
    rchk(`IDX_TIMER, 8'h00);
    rchk(`IDX_IRQ_FLAG, 8'h00);
    bus(1'b1, `IDX_IRQ_EN, 8'h01);
    rchk(`IDX_IRQ_FLAG, 8'h01);
    bus(1'b1, `IDX_IRQ_FLAG, 8'h00);
    bus(1'b1, `IDX_WAKE_EN, 8'h02);
    bus(1'b0, `IDX_PORT_DATA, 8'h00);
    bus(1'b1, `IDX_IRQ_EN, 8'h02);
    set_pins(8'h04);
    rchk(`IDX_IRQ_FLAG, 8'h00);
    core.issue(1'b1);
    @(posedge clk_i);
    chk({slp, osc_en}, 2'b10);
    set_pins(8'h06);
    wait_for(1);
    chk(cyc >= DLY + 250, 1'b1);
    rchk(`IDX_STATUS, 8'h10);
    set_pins(8'h04);
    bus(1'b1, `IDX_IRQ_FLAG, 8'h00);
    bus(1'b1, `IDX_IRQ_EN, 8'h82);
    core.issue(1'b1);
    set_pins(8'h06);
    wait_for(2);
    rchk(`IDX_IRQ_EN, 8'h02);
    rchk(`IDX_IRQ_FLAG, 8'h02);
    set_pins(8'h04);
    bus(1'b1, `IDX_PWRCTL, 8'h60);
    bus(1'b1, `IDX_WAKE_EN, 8'h01);
    bus(1'b0, `IDX_PORT_DATA, 8'h00);
    bus(1'b1, `IDX_IRQ_FLAG, 8'h00);
    set_pins(8'h05);
    rchk(`IDX_IRQ_FLAG, 8'h00);
    bus(1'b1, `IDX_PIN_DIR, 8'hF0);
    bus(1'b1, `IDX_PORT_DATA, 8'h05);
    bus(1'b1, `IDX_OPENDRAIN, 8'h01);
    @(posedge clk_i);
    chk({pout, poe}, 16'h050E);
    bus(1'b1, `IDX_TIMER, 8'h5A);
    bus(1'b1, `IDX_PWRCTL, 8'hA0);
    core.issue(1'b1);
    wait_for(3);
    wait_for(0);
    rchk(`IDX_STATUS, 8'h00);
    rchk(`IDX_PIN_DIR, 8'hFF);
    bus(1'b1, `IDX_PWRCTL, 8'h20);
    hit(1'b0, 3);
    rchk(`IDX_STATUS, 8'h00);
    bus(1'b1, `IDX_PWRCTL, 8'h20);
    core.issue(1'b0);
    @(posedge clk_i);
    rchk(`IDX_STATUS, 8'h18);
    core.issue(1'b1);
    hit(1'b0, 3);
    rchk(`IDX_STATUS, 8'h10);
    bus(1'b1, `IDX_PWRCTL, 8'h20);
    hit(1'b1, 40);
    chk(cyc >= DLY + 250, 1'b1);
    rchk(`IDX_STATUS, 8'h18);
    rchk(`IDX_TIMER, 8'h5A);
    test_done;
  end
endmodule // reset_sleep_wake_sequencer_bench
